/* rtl/mdio_pkg.sv */
/*
  Shared constants and types for the serial management slave.
  Assumes a 16-bit register set addressed by a 5-bit field.
*/
package mdio_pkg;

  localparam int DATA_W = 16;
  localparam int FIELD_W = 5;
  localparam int MGMT_PREAMBLE_LEN = 32;

  // frame codes
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  // register offsets
  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam logic [4:0] REG_ID_HI = 5'h02;
  localparam logic [4:0] REG_ID_LO = 5'h03;
  localparam logic [4:0] REG_EXT_CTRL = 5'h10;

  // field positions
  localparam int STATUS_PRE_SUPPRESS_BIT = 6;
  localparam int EXT_OVERRIDE_BIT = 15;
  localparam int EXT_PHYAD_LSB = 6;

  // values after reset
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RO_VALUE = 16'h0000;
  localparam logic [4:0] PHYAD_RESET = 5'h00;
  localparam logic [15:0] UNMAPPED_READ = 16'hFFFF;

  // identity words, arbitrary values
  localparam logic [15:0] ID_HI_VALUE = 16'h1234;
  localparam logic [15:0] ID_LO_VALUE = 16'h5670;

  // cycles for the strap synchroniser to settle after reset
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef enum logic [3:0] {
    LS_HUNT,
    LS_START,
    LS_OPCODE,
    LS_PHYAD,
    LS_REGAD,
    LS_TURN,
    LS_TURN2,
    LS_RDATA,
    LS_WDATA
  } link_state_t;

endpackage

/* rtl/mdio_reg_bank.sv */
/*
  Management register bank on the system clock.
  Assumes write strobes arrive as one-cycle pulses with stable address and data.
*/
`timescale 1ns/10ps
`default_nettype none

module mdio_reg_bank
  import mdio_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [4:0] strapAddr,
  input wire logic wrEn,
  input wire logic [4:0] wrAddr,
  input wire logic [15:0] wrData,
  input wire logic [4:0] rdAddr,
  output logic [15:0] rdData,
  output logic [15:0] controlWord,
  output logic preSuppress,
  output logic [4:0] phyAddr
);

  function automatic logic isMapped(input logic [4:0] a);
    isMapped = (a == REG_CONTROL) || (a == REG_STATUS) || (a == REG_ID_HI) ||
               (a == REG_ID_LO) || (a == REG_EXT_CTRL);
  endfunction

  logic overrideBit;
  logic strapTaken;
  logic [1:0] strapWait;

  wire logic wrMapped = wrEn && isMapped(wrAddr);
  wire logic wrControl = wrMapped && (wrAddr == REG_CONTROL);
  wire logic wrStatus = wrMapped && (wrAddr == REG_STATUS);
  wire logic wrExt = wrMapped && (wrAddr == REG_EXT_CTRL);

  wire logic [15:0] statusWord = STATUS_RO_VALUE |
    (16'(preSuppress) << STATUS_PRE_SUPPRESS_BIT);
  wire logic [15:0] extWord = (16'(overrideBit) << EXT_OVERRIDE_BIT) |
    (16'(phyAddr) << EXT_PHYAD_LSB);

  // read decode; unmapped addresses answer all ones
  assign rdData = !isMapped(rdAddr) ? UNMAPPED_READ : // RULE_12
                  (rdAddr == REG_CONTROL) ? controlWord :
                  (rdAddr == REG_STATUS) ? statusWord :
                  (rdAddr == REG_ID_HI) ? ID_HI_VALUE :
                  (rdAddr == REG_ID_LO) ? ID_LO_VALUE : extWord;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      controlWord <= CONTROL_RESET; // RULE_20
    end else if (wrControl) begin
      controlWord <= wrData; // RULE_11
    end
  end

  // override-gated suppression bit; other status bits read only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      preSuppress <= 1'b0; // RULE_03
    end else if (wrStatus && overrideBit) begin
      preSuppress <= wrData[STATUS_PRE_SUPPRESS_BIT]; // RULE_18 RULE_19
    end
  end

  // override clears on any following write to another mapped register; unmapped writes leave it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrideBit <= 1'b0;
    end else if (wrExt) begin
      overrideBit <= wrData[EXT_OVERRIDE_BIT];
    end else if (wrMapped) begin
      overrideBit <= 1'b0; // RULE_18
    end
  end

  // address strap caught once the synchroniser has settled
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strapWait <= 2'h0;
      strapTaken <= 1'b0;
      phyAddr <= PHYAD_RESET;
    end else if (!strapTaken) begin
      if (strapWait == STRAP_SETTLE) begin
        phyAddr <= strapAddr;
        strapTaken <= 1'b1;
      end else begin
        strapWait <= strapWait + 2'h1;
      end
    end
  end

endmodule

`default_nettype wire

/* rtl/mdio_management_slave.sv */
/*
  Serial management slave: frame decoder on the management clock and
  register bank on the system clock, joined by toggle handshakes.
  Assumes the station drives the management clock and pulls the data
  line high when nobody drives it.
*/
`timescale 1ns/10ps
`default_nettype none

// Operation
// [RULE_01] without suppression, 32 ones on the line precede a frame
// [RULE_02] suppression bit chooses preamble hunt or direct frame hunt
// [RULE_03] suppression resets to zero, set only after override write
// [RULE_04] start delimiter zero then one follows the preamble
// [RULE_05] opcode 10 reads, 01 writes, 00 and 11 ignored
// [RULE_06] frame answered only when its address equals stored address
// [RULE_07] 5-bit register field picks source or destination register
// [RULE_08] read turnaround: released first bit, zero second bit
// [RULE_09] write turnaround: station drives one then zero
// [RULE_10] read shifts out 16 register bits after turnaround
// [RULE_11] write stores 16 received bits in the addressed register
// [RULE_12] read of unimplemented register returns all ones
// [RULE_13] write to unimplemented register changes nothing
// [RULE_14] data travels most significant bit first
// [RULE_15] data pin released between transactions
// [RULE_16] back-to-back frames accepted without idle bits
// [RULE_17] every line bit is timed by the station clock
// [RULE_18] gated bits change only with override set; override self-clears
// [RULE_19] writes to read-only bits are ignored
// [RULE_20] every register returns to its default after reset
// [RULE_21] sample on rising edge, drive just after it
// [RULE_22] bad opcode or address mismatch: stay released, hunt again
module mdio_management_slave
  import mdio_pkg::*;
#(
  parameter int PREAMBLE_ONES = MGMT_PREAMBLE_LEN
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic mgmtClk,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  input wire logic [4:0] phyAddrStrap,
  output logic [15:0] controlWord,
  output logic preambleSuppressed
);

  generate
    if (PREAMBLE_ONES < 1 || PREAMBLE_ONES > 63) begin : gBadPre
      $error("PREAMBLE_ONES must lie in 1..63");
    end
    if (DATA_W != 16 || FIELD_W != 5) begin : gBadWidth
      $error("link fields must be 16 data bits and 5 address bits");
    end
  endgenerate

  function automatic logic opcodeValid(input logic [1:0] op);
    opcodeValid = (op == OP_READ) || (op == OP_WRITE);
  endfunction

  localparam logic [5:0] PRE_TARGET = 6'(PREAMBLE_ONES);
  localparam logic [4:0] FIELD_LAST = 5'(FIELD_W - 1);
  localparam logic [4:0] DATA_LAST = 5'(DATA_W - 1);

  // ---------------- link side, management clock ----------------

  link_state_t state;
  link_state_t next_state;
  logic [4:0] bitCnt;
  logic [4:0] next_bitCnt;
  logic [5:0] preCnt;
  logic [5:0] next_preCnt;
  logic [1:0] opcode;
  logic [1:0] next_opcode;
  logic [4:0] fieldShift;
  logic [4:0] regAddr;
  logic [4:0] next_regAddr;
  logic [15:0] rxShift;
  logic [15:0] txShift;
  logic [15:0] next_txShift;
  logic next_mdioOut;
  logic next_mdioOe;
  logic rdToggle;
  logic next_rdToggle;
  logic wrToggle;
  logic next_wrToggle;
  logic [4:0] wrAddr;
  logic [15:0] wrData;
  logic captureWrite;

  logic supSync1;
  logic supSync2;
  logic [4:0] adSync1;
  logic [4:0] adSync2;

  logic [15:0] readHold;
  logic [4:0] phyAddr;

  // bank state brought onto the management clock
  always_ff @(posedge mgmtClk or negedge rst_n) begin
    if (!rst_n) begin
      supSync1 <= 1'b0;
      supSync2 <= 1'b0;
    end else begin
      supSync1 <= preambleSuppressed;
      supSync2 <= supSync1;
    end
  end

  // stored address, two flip-flops per bit
  generate
    for (genvar i = 0; i < FIELD_W; i++) begin : gAddrSync
      always_ff @(posedge mgmtClk or negedge rst_n) begin
        if (!rst_n) begin
          adSync1[i] <= PHYAD_RESET[i];
          adSync2[i] <= PHYAD_RESET[i];
        end else begin
          adSync1[i] <= phyAddr[i];
          adSync2[i] <= adSync1[i];
        end
      end
    end
  endgenerate

  wire logic preambleMet = (preCnt == PRE_TARGET) || supSync2; // RULE_01 RULE_02
  wire logic [4:0] fieldNext = {fieldShift[3:0], mdioIn}; // RULE_21
  wire logic [1:0] opcodeNext = {opcode[0], mdioIn};
  wire logic opcodeOk = opcodeValid(opcodeNext);
  wire logic [15:0] rxNext = {rxShift[14:0], mdioIn}; // RULE_14
  wire logic isRead = (opcode == OP_READ);
  wire logic fieldDone = (bitCnt == FIELD_LAST);
  wire logic dataDone = (bitCnt == DATA_LAST);
  wire logic [5:0] preInc = (preCnt == PRE_TARGET) ? preCnt : preCnt + 6'h01;

  always_comb begin
    next_state = state;
    next_bitCnt = bitCnt + 5'h01;
    next_preCnt = 6'h00;
    next_opcode = opcode;
    next_regAddr = regAddr;
    next_txShift = txShift;
    next_mdioOut = mdioOut;
    next_mdioOe = mdioOe;
    next_rdToggle = rdToggle;
    next_wrToggle = wrToggle;
    captureWrite = 1'b0;
    case (state)
      LS_HUNT: begin
        next_bitCnt = 5'h00;
        next_mdioOe = 1'b0; // RULE_15
        if (mdioIn) begin
          next_preCnt = preInc; // RULE_01
        end else if (preambleMet) begin
          next_state = LS_START; // RULE_04
        end
      end
      LS_START: begin
        next_bitCnt = 5'h00;
        next_state = mdioIn ? LS_OPCODE : LS_HUNT; // RULE_04
      end
      LS_OPCODE: begin
        next_opcode = opcodeNext;
        if (bitCnt != 5'h00) begin
          next_bitCnt = 5'h00;
          if (opcodeOk) begin
            next_state = LS_PHYAD; // RULE_05
          end else begin
            next_state = LS_HUNT; // RULE_05 RULE_22
          end
        end
      end
      LS_PHYAD: begin
        if (fieldDone) begin
          next_bitCnt = 5'h00;
          next_state = (fieldNext == adSync2) ? LS_REGAD : LS_HUNT; // RULE_06 RULE_22
        end
      end
      LS_REGAD: begin
        if (fieldDone) begin
          next_regAddr = fieldNext; // RULE_07
          next_rdToggle = rdToggle ^ isRead;
          next_state = LS_TURN;
        end
      end
      LS_TURN: begin
        if (isRead) begin
          next_mdioOe = 1'b1; // RULE_08
          next_mdioOut = 1'b0;
        end
        next_state = LS_TURN2;
      end
      LS_TURN2: begin
        next_bitCnt = 5'h00;
        if (isRead) begin
          next_txShift = readHold; // RULE_10
          next_mdioOut = readHold[15]; // RULE_14
          next_state = LS_RDATA;
        end else begin
          next_state = LS_WDATA; // RULE_09
        end
      end
      LS_RDATA: begin
        if (dataDone) begin
          next_mdioOe = 1'b0; // RULE_15
          next_state = LS_HUNT; // RULE_16
        end else begin
          next_txShift = {txShift[14:0], 1'b0};
          next_mdioOut = txShift[14]; // RULE_10 RULE_21
        end
      end
      LS_WDATA: begin
        if (dataDone) begin
          captureWrite = 1'b1;
          next_wrToggle = ~wrToggle; // RULE_11
          next_state = LS_HUNT; // RULE_16
        end
      end
      default: begin
        next_state = LS_HUNT;
      end
    endcase
  end

  always_ff @(posedge mgmtClk or negedge rst_n) begin
    if (!rst_n) begin
      state <= LS_HUNT;
      bitCnt <= 5'h00;
      preCnt <= 6'h00;
      opcode <= 2'h0;
    end else begin
      state <= next_state; // RULE_17
      bitCnt <= next_bitCnt;
      preCnt <= next_preCnt;
      opcode <= next_opcode;
    end
  end

  always_ff @(posedge mgmtClk or negedge rst_n) begin
    if (!rst_n) begin
      fieldShift <= 5'h00;
      rxShift <= 16'h0000;
      regAddr <= 5'h00;
    end else begin
      fieldShift <= fieldNext;
      rxShift <= rxNext;
      regAddr <= next_regAddr;
    end
  end

  always_ff @(posedge mgmtClk or negedge rst_n) begin
    if (!rst_n) begin
      txShift <= 16'h0000;
      mdioOut <= 1'b0;
      mdioOe <= 1'b0;
    end else begin
      txShift <= next_txShift;
      mdioOut <= next_mdioOut;
      mdioOe <= next_mdioOe;
    end
  end

  // request toggles with address and data held until the next toggle
  always_ff @(posedge mgmtClk or negedge rst_n) begin
    if (!rst_n) begin
      rdToggle <= 1'b0;
      wrToggle <= 1'b0;
      wrAddr <= 5'h00;
      wrData <= 16'h0000;
    end else begin
      rdToggle <= next_rdToggle;
      wrToggle <= next_wrToggle;
      if (captureWrite) begin
        wrAddr <= regAddr;
        wrData <= rxNext;
      end
    end
  end

  // ---------------- bank side, system clock ----------------

  logic [2:0] rdSync;
  logic [2:0] wrSync;
  logic [4:0] strapSync1;
  logic [4:0] strapSync2;
  logic [15:0] rdData;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdSync <= 3'h0;
      wrSync <= 3'h0;
    end else begin
      rdSync <= {rdSync[1:0], rdToggle};
      wrSync <= {wrSync[1:0], wrToggle};
    end
  end

  // address strap pins, two flip-flops per pin
  generate
    for (genvar i = 0; i < FIELD_W; i++) begin : gStrapSync
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          strapSync1[i] <= 1'b0;
          strapSync2[i] <= 1'b0;
        end else begin
          strapSync1[i] <= phyAddrStrap[i];
          strapSync2[i] <= strapSync1[i];
        end
      end
    end
  endgenerate

  wire logic rdPulse = rdSync[2] ^ rdSync[1];
  wire logic wrPulse = wrSync[2] ^ wrSync[1];

  // read word parked for the link well before the turnaround ends
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      readHold <= UNMAPPED_READ;
    end else if (rdPulse) begin
      readHold <= rdData; // RULE_07 RULE_12
    end
  end

  mdio_reg_bank uBank (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .strapAddr(strapSync2),
    .wrEn(wrPulse), // RULE_13
    .wrAddr(wrAddr),
    .wrData(wrData),
    .rdAddr(regAddr),
    .rdData(rdData),
    .controlWord(controlWord),
    .preSuppress(preambleSuppressed),
    .phyAddr(phyAddr)
  );

endmodule

`default_nettype wire

/* dv/mdio_management_slave_props.sv */
/*
  Concurrent checks on the management slave ports.
  Assumes a pulled-up data wire and a station clock that stops between frames.
*/
`timescale 1ns/10ps
`default_nettype none

module mdio_management_slave_props
  import mdio_pkg::*;
#(
  parameter int PREAMBLE_ONES = MGMT_PREAMBLE_LEN
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic mgmtClk,
  input wire logic mdioIn,
  input wire logic mdioOut,
  input wire logic mdioOe,
  input wire logic [4:0] phyAddrStrap,
  input wire logic [15:0] controlWord,
  input wire logic preambleSuppressed
);
  logic [79:0] hist;
  logic [79:0] need;
  logic [1:0] clkSync;
  logic [7:0] quiet;
  assign need = (80'h1 << PREAMBLE_ONES) - 80'h1;
  // line history, hist[k] is the bit sampled k+1 edges ago
  always_ff @(posedge mgmtClk or negedge rst_n) begin
    if (!rst_n) begin
      hist <= '0;
    end else begin
      hist <= {hist[78:0], mdioIn};
    end
  end
  // system cycles since the station clock was last seen high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkSync <= 2'h0;
      quiet <= 8'h00;
    end else begin
      clkSync <= {clkSync[0], mgmtClk};
      quiet <= clkSync[1] ? 8'h00 : ((quiet == 8'hFF) ? quiet : quiet + 8'h01);
    end
  end
  a_read_opcode: assert property (@(posedge mgmtClk) disable iff (!rst_n)
    $rose(mdioOe) |-> hist[12:11] == 2'h2) else $error("drive without read opcode");
  a_start_delim: assert property (@(posedge mgmtClk) disable iff (!rst_n)
    $rose(mdioOe) |-> hist[14:13] == 2'h1) else $error("drive without start delimiter");
  a_addr_match: assert property (@(posedge mgmtClk) disable iff (!rst_n)
    $rose(mdioOe) |-> hist[10:6] == phyAddrStrap) else $error("drive on foreign address");
  a_turn_bits: assert property (@(posedge mgmtClk) disable iff (!rst_n)
    $rose(mdioOe) |-> hist[0] && !$past(mdioOe) && !mdioOut) else $error("turnaround wrong");
  a_drive_len: assert property (@(posedge mgmtClk) disable iff (!rst_n)
    $rose(mdioOe) |-> mdioOe[*8] ##1 mdioOe[*8] ##1 mdioOe ##1 !mdioOe)
    else $error("drive window not 17 bits");
  a_need_preamble: assert property (@(posedge mgmtClk) disable iff (!rst_n)
    $rose(mdioOe) && !preambleSuppressed |-> ((hist >> 15) & need) == need)
    else $error("answer without preamble");
  a_reset_values: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(rst_n) |-> controlWord == CONTROL_RESET && !preambleSuppressed)
    else $error("register not at reset value");
  a_update_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(controlWord) || $changed(preambleSuppressed) |-> quiet < 8'h10)
    else $error("register changed without link activity");
  cover property (@(posedge mgmtClk) $rose(mdioOe));
  cover property (@(posedge ref_clk) $rose(preambleSuppressed));
  cover property (@(posedge ref_clk) $changed(controlWord));
endmodule

bind mdio_management_slave mdio_management_slave_props #(.PREAMBLE_ONES(PREAMBLE_ONES))
  mdio_management_slave_props_inst (.ref_clk(ref_clk), .rst_n(rst_n), .mgmtClk(mgmtClk),
  .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe), .phyAddrStrap(phyAddrStrap),
  .controlWord(controlWord), .preambleSuppressed(preambleSuppressed));

`default_nettype wire

/* dv/mdio_station.sv */
/*
  Station model: makes the management clock within frames and drives frames.
  Assumes a pull-up on the data wire; the clock rests low between frames.
*/
`timescale 1ns/10ps
`default_nettype none

module mdio_station
  import mdio_pkg::*;
(
  output logic mgmtClk,
  output logic mdioIn,
  input wire logic mdioOut,
  input wire logic mdioOe
);
  logic drv = 1'b0;
  logic val = 1'b1;
  initial mgmtClk = 1'b0;
  // wire level: device, station, else pull-up
  assign mdioIn = mdioOe ? mdioOut : (drv ? val : 1'b1);
  // one bit: change after falling edge, sample before rising edge
  task automatic bitx(input logic d, input logic v, output logic s);
    drv = d;
    val = v;
    #24;
    s = mdioIn;
    mgmtClk = 1'b1;
    #24;
    mgmtClk = 1'b0;
  endtask
  task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] phy,
    input logic [4:0] ra, input logic [15:0] wd, output logic [16:0] rd);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b01, op, phy, ra};
    rd = 17'h1FFFF;
    if (pre) begin
      for (int i = 0; i < 32; i++) bitx(1'b1, 1'b1, s);
    end
    for (int i = 13; i >= 0; i--) bitx(1'b1, hdr[i], s);
    if (op == OP_READ) begin
      bitx(1'b0, 1'b1, s);
      bitx(1'b0, 1'b1, s);
      rd[16] = s;
      for (int i = 15; i >= 0; i--) begin
        bitx(1'b0, 1'b1, s);
        rd[i] = s;
      end
    end else begin
      bitx(1'b1, 1'b1, s);
      bitx(1'b1, 1'b0, s);
      for (int i = 15; i >= 0; i--) bitx(1'b1, wd[i], s);
    end
    drv = 1'b0;
  endtask
endmodule

`default_nettype wire

/* dv/mdio_management_slave_tb.sv */
/*
  Self-checking bench for the management slave.
  Assumes the station model drives the link; strap pins held at one address.
*/
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp=%h got=%h", nm, e, g); end end

module mdio_management_slave_tb
  import mdio_pkg::*;
;
  localparam logic [4:0] PHY = 5'h0A;
  localparam logic [15:0] EXT = 16'(PHY) << EXT_PHYAD_LSB;
  logic ref_clk, rst_n, mgmtClk, mdioIn, mdioOut, mdioOe, preambleSuppressed;
  logic [4:0] phyAddrStrap;
  logic [15:0] controlWord;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  mdio_management_slave mdio_management_slave_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .mgmtClk(mgmtClk), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe),
    .phyAddrStrap(phyAddrStrap), .controlWord(controlWord),
    .preambleSuppressed(preambleSuppressed));
  mdio_station mdio_station_inst (.mgmtClk(mgmtClk), .mdioIn(mdioIn), .mdioOut(mdioOut),
    .mdioOe(mdioOe));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic wr(input logic pre, input logic [1:0] op, input logic [4:0] phy,
    input logic [4:0] ra, input logic [15:0] d);
    logic [16:0] r;
    mdio_station_inst.frame(pre, op, phy, ra, d, r);
  endtask
  task automatic rdChk(input logic pre, input logic [4:0] phy, input logic [4:0] ra,
    input logic [16:0] e);
    logic [16:0] r;
    mdio_station_inst.frame(pre, OP_READ, phy, ra, 16'h0000, r);
    `CHK("read", e, r)
  endtask

  task automatic s_reset();
    `CHK("control", CONTROL_RESET, controlWord)
    `CHK("suppress", 1'b0, preambleSuppressed)
    rdChk(1'b1, PHY, REG_CONTROL, {1'b0, CONTROL_RESET});
    rdChk(1'b1, PHY, REG_STATUS, {1'b0, STATUS_RO_VALUE});
    rdChk(1'b1, PHY, REG_ID_HI, {1'b0, ID_HI_VALUE});
    rdChk(1'b1, PHY, REG_ID_LO, {1'b0, ID_LO_VALUE});
    rdChk(1'b1, PHY, REG_EXT_CTRL, {1'b0, EXT});
    rdChk(1'b1, PHY, 5'h1F, {1'b0, UNMAPPED_READ});
  endtask

  task automatic s_write();
    wr(1'b1, OP_WRITE, PHY, REG_CONTROL, 16'hA5C3);
    rdChk(1'b1, PHY, REG_CONTROL, {1'b0, 16'hA5C3});
    `CHK("control", 16'hA5C3, controlWord)
    wr(1'b1, OP_WRITE, PHY, 5'h07, 16'h0000);
    wr(1'b1, OP_WRITE, PHY, REG_ID_HI, 16'h0000);
    rdChk(1'b1, PHY, REG_ID_HI, {1'b0, ID_HI_VALUE});
    rdChk(1'b1, PHY, 5'h07, {1'b0, UNMAPPED_READ});
    `CHK("control", 16'hA5C3, controlWord)
  endtask

  task automatic s_refuse();
    wr(1'b1, 2'h0, PHY, REG_CONTROL, 16'h0000);
    wr(1'b1, 2'h3, PHY, REG_CONTROL, 16'h0000);
    rdChk(1'b1, PHY ^ 5'h01, REG_CONTROL, 17'h1FFFF);
    wr(1'b0, OP_WRITE, PHY, REG_CONTROL, 16'h0000);
    repeat (10) @(posedge ref_clk);
    `CHK("control", 16'hA5C3, controlWord)
  endtask

  task automatic s_suppress();
    wr(1'b1, OP_WRITE, PHY, REG_STATUS, 16'h0040);
    repeat (10) @(posedge ref_clk);
    `CHK("suppress", 1'b0, preambleSuppressed)
    wr(1'b1, OP_WRITE, PHY, REG_EXT_CTRL, 16'h8000);
    rdChk(1'b1, PHY, REG_EXT_CTRL, {1'b0, 16'h8000 | EXT});
    wr(1'b1, OP_WRITE, PHY, REG_STATUS, 16'h0040);
    repeat (10) @(posedge ref_clk);
    `CHK("suppress", 1'b1, preambleSuppressed)
    rdChk(1'b1, PHY, REG_EXT_CTRL, {1'b0, EXT});
    rdChk(1'b0, PHY, REG_STATUS, {1'b0, 16'h0040});
    wr(1'b0, OP_WRITE, PHY, REG_CONTROL, 16'h0F0F);
    rdChk(1'b0, PHY, REG_CONTROL, {1'b0, 16'h0F0F});
  endtask

  task automatic s_rereset();
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
    `CHK("control", CONTROL_RESET, controlWord)
    `CHK("suppress", 1'b0, preambleSuppressed)
    rdChk(1'b1, PHY, REG_CONTROL, {1'b0, CONTROL_RESET});
  endtask

  initial begin
    rst_n <= 1'b0;
    phyAddrStrap <= PHY;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
    s_reset();
    s_write();
    s_refuse();
    s_suppress();
    s_rereset();
    wrap_up();
  end
endmodule

`default_nettype wire
